/* File: inc/jump_dec_pkg.sv */
// Contract
// - Command word 250 is the input-AND jump: four words holding command, enable mask, state mask, target.
// - The 16-bit enable mask picks which input-state bits are evaluated; disabled bits are ignored.
// - For each enabled input the state mask bit gives the level (1 high, 0 low) that counts as true.
// - Enable mask and state mask both zero make the input-AND jump branch unconditionally.
// - Register jumps use command 137, five words, comparison kind in the operand high byte, register in the low.
// - Operation 1 branches when the register is greater or equal to the value; any register number allowed.
// - Operation 4 branches when the register is strictly greater; only standard-range registers allowed.
// - The compare value is signed 32-bit and the comparison is signed.
// - A jump target is an unsigned 16-bit program buffer address.
`default_nettype none

package jump_dec_pkg;

    // ****************************************
    // Command codes and operation codes
    // ****************************************
    localparam logic [15:0] CMD_INPUT_AND = 16'h00FA;
    localparam logic [15:0] CMD_REG_CMP = 16'h0089;
    localparam logic [7:0] OP_GREATER_EQUAL = 8'h01;
    localparam logic [7:0] OP_GREATER_THAN = 8'h04;

    // ****************************************
    // Instruction lengths and word slots
    // ****************************************
    localparam logic [2:0] LEN_INPUT_AND = 3'h4;
    localparam logic [2:0] LEN_REG_CMP = 3'h5;
    localparam logic [2:0] LEN_MAX = 3'h5;
    localparam int W_CMD = 0;
    localparam int W_ENABLE = 1;
    localparam int W_STATE = 2;
    localparam int W_AND_TARGET = 3;
    localparam int W_OPREG = 1;
    localparam int W_VAL_HI = 2;
    localparam int W_VAL_LO = 3;
    localparam int W_REG_TARGET = 4;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] REG_ADDR_RESET = 8'h00;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_CAPTURE, ST_EXEC} seq_state_t;

endpackage

`default_nettype wire

/* File: inc/prog_mem_if.sv */
`default_nettype none

interface prog_mem_if #(
    parameter int AW = 13
) ();
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [15:0] wr_data;
    logic rd_en;
    logic [AW-1:0] rd_addr;
    logic [15:0] rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
endinterface

`default_nettype wire

/* File: hw/prog_buffer_mem.sv */
`default_nettype none

module prog_buffer_mem #(
    parameter int DEPTH = 5120,
    parameter int AW = 13
) (
    input wire logic ref_clk,
    prog_mem_if.mem bus
);
    generate
        if (DEPTH < 1 || AW < $clog2(DEPTH)) begin : g_bad_size
            $error("AW too narrow for DEPTH");
        end
    endgenerate

    logic [15:0] mem_q [DEPTH];

    // No reset: contents are whatever the host loaded
    always_ff @(posedge ref_clk) begin
        if (bus.wr_en) begin
            mem_q[bus.wr_addr] <= bus.wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (bus.rd_en) begin
            bus.rd_data <= mem_q[bus.rd_addr];
        end
    end
endmodule

`default_nettype wire

/* File: hw/conditional_jump_decoder.sv */
`default_nettype none

module conditional_jump_decoder #(
    parameter int DEPTH = 5120,
    parameter logic [7:0] STD_REG_LAST = 8'h3F
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic load_valid,
    input wire logic [15:0] load_addr,
    input wire logic [15:0] load_data,
    input wire logic pc_set,
    input wire logic [15:0] pc_set_value,
    input wire logic step_req,
    input wire logic [15:0] input_state_word,
    input wire logic [31:0] reg_rd_data,
    output logic [7:0] reg_rd_addr,
    output logic [15:0] pc,
    output logic busy,
    output logic step_done,
    output logic branch_taken,
    output logic bad_instr
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    generate
        if (DEPTH < 5 || DEPTH > 65536) begin : g_bad_depth
            $error("DEPTH must lie between 5 and 65536");
        end
    endgenerate

    // ****************************************
    // Program buffer
    // ****************************************
    prog_mem_if #(.AW(AW)) mem_bus ();

    prog_buffer_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
        .ref_clk(ref_clk),
        .bus(mem_bus)
    );

    jump_dec_pkg::seq_state_t state_q;
    logic [15:0] pc_q;
    logic [2:0] idx_q;
    logic [2:0] len_q;
    logic [15:0] w_q [jump_dec_pkg::LEN_MAX];
    logic [15:0] io_meta_q;
    logic [15:0] io_sync_q;
    logic [15:0] pc_word;
    logic [2:0] len_d;
    logic and_match;
    logic [7:0] op_code;
    logic [7:0] reg_num;
    logic signed [31:0] cmp_value;
    logic signed [31:0] reg_value;

    // Loads are refused while a step runs so a fetch never sees a half-written program
    assign mem_bus.wr_en = load_valid && (state_q == jump_dec_pkg::ST_IDLE) && ({16'h0000, load_addr} < DEPTH);
    assign mem_bus.wr_addr = load_addr[AW-1:0];
    assign mem_bus.wr_data = load_data;
    assign pc_word = pc_q + {13'h0000, idx_q};
    assign mem_bus.rd_en = (state_q == jump_dec_pkg::ST_READ);
    assign mem_bus.rd_addr = pc_word[AW-1:0];

    // ****************************************
    // Input state synchroniser
    // ****************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            io_meta_q <= 16'h0000;
            io_sync_q <= 16'h0000;
        end else begin
            io_meta_q <= input_state_word;
            io_sync_q <= io_meta_q;
        end
    end

    // ****************************************
    // Decode and evaluation
    // ****************************************
    always_comb begin
        if (mem_bus.rd_data == jump_dec_pkg::CMD_INPUT_AND) begin
            len_d = jump_dec_pkg::LEN_INPUT_AND;
        end else if (mem_bus.rd_data == jump_dec_pkg::CMD_REG_CMP) begin
            len_d = jump_dec_pkg::LEN_REG_CMP;
        end else begin
            len_d = 3'h0;
        end
    end

    // Disabled bits forced true; all-zero masks therefore always match
    assign and_match = &(~w_q[jump_dec_pkg::W_ENABLE]
        | ~(io_sync_q ^ w_q[jump_dec_pkg::W_STATE]));
    assign op_code = w_q[jump_dec_pkg::W_OPREG][15:8];
    assign reg_num = w_q[jump_dec_pkg::W_OPREG][7:0];
    assign cmp_value = {w_q[jump_dec_pkg::W_VAL_HI], w_q[jump_dec_pkg::W_VAL_LO]};
    assign reg_value = reg_rd_data;

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= jump_dec_pkg::ST_IDLE;
            idx_q <= 3'h0;
            len_q <= 3'h0;
        end else begin
            case (state_q)
                jump_dec_pkg::ST_IDLE: begin
                    if (step_req && !pc_set) begin
                        state_q <= jump_dec_pkg::ST_READ;
                        idx_q <= 3'h0;
                    end
                end
                jump_dec_pkg::ST_READ: begin
                    state_q <= jump_dec_pkg::ST_CAPTURE;
                end
                jump_dec_pkg::ST_CAPTURE: begin
                    if (idx_q == 3'h0) begin
                        len_q <= len_d;
                    end
                    if ((idx_q == 3'h0 && len_d == 3'h0) || (idx_q != 3'h0 && idx_q + 3'h1 == len_q)) begin
                        state_q <= jump_dec_pkg::ST_EXEC;
                    end else begin
                        idx_q <= idx_q + 3'h1;
                        state_q <= jump_dec_pkg::ST_READ;
                    end
                end
                jump_dec_pkg::ST_EXEC: begin
                    state_q <= jump_dec_pkg::ST_IDLE;
                end
                default: begin
                    state_q <= jump_dec_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < jump_dec_pkg::LEN_MAX; i++) begin
                w_q[i] <= 16'h0000;
            end
        end else if (state_q == jump_dec_pkg::ST_CAPTURE) begin
            w_q[idx_q] <= mem_bus.rd_data;
        end
    end

    // Register address settles at least two cycles before evaluation
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rd_addr <= jump_dec_pkg::REG_ADDR_RESET;
        end else if (state_q == jump_dec_pkg::ST_CAPTURE && idx_q == 3'(jump_dec_pkg::W_OPREG)) begin
            reg_rd_addr <= mem_bus.rd_data[7:0];
        end
    end

    // ****************************************
    // Program counter and outcome
    // ****************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pc_q <= jump_dec_pkg::PC_RESET;
            branch_taken <= 1'b0;
            bad_instr <= 1'b0;
        end else if (state_q == jump_dec_pkg::ST_IDLE && pc_set) begin
            pc_q <= pc_set_value;
        end else if (state_q == jump_dec_pkg::ST_EXEC) begin
            branch_taken <= 1'b0;
            bad_instr <= 1'b0;
            if (w_q[jump_dec_pkg::W_CMD] == jump_dec_pkg::CMD_INPUT_AND) begin
                if (and_match) begin
                    pc_q <= w_q[jump_dec_pkg::W_AND_TARGET];
                    branch_taken <= 1'b1;
                end else begin
                    pc_q <= pc_q + 16'(jump_dec_pkg::LEN_INPUT_AND);
                end
            end else if (w_q[jump_dec_pkg::W_CMD] == jump_dec_pkg::CMD_REG_CMP &&
                         (op_code == jump_dec_pkg::OP_GREATER_EQUAL ||
                          (op_code == jump_dec_pkg::OP_GREATER_THAN && reg_num <= STD_REG_LAST))) begin
                if ((op_code == jump_dec_pkg::OP_GREATER_EQUAL && reg_value >= cmp_value) ||
                    (op_code == jump_dec_pkg::OP_GREATER_THAN && reg_value > cmp_value)) begin
                    pc_q <= w_q[jump_dec_pkg::W_REG_TARGET];
                    branch_taken <= 1'b1;
                end else begin
                    pc_q <= pc_q + 16'(jump_dec_pkg::LEN_REG_CMP);
                end
            end else begin
                // Unknown command, operation or out-of-range register: stop here, host decides
                bad_instr <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
            step_done <= 1'b0;
        end else begin
            busy <= (state_q == jump_dec_pkg::ST_IDLE) ? (step_req && !pc_set) : (state_q != jump_dec_pkg::ST_EXEC);
            step_done <= (state_q == jump_dec_pkg::ST_EXEC);
        end
    end

    assign pc = pc_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    logic ex_and;
    logic ex_reg;
    assign ex_and = (state_q == jump_dec_pkg::ST_EXEC) && w_q[0] == jump_dec_pkg::CMD_INPUT_AND;
    assign ex_reg = (state_q == jump_dec_pkg::ST_EXEC) && w_q[0] == jump_dec_pkg::CMD_REG_CMP;

    a_and_length: assert property (ex_and |=> step_done && !bad_instr && !busy)
        else $error("input-AND step not completed");
    a_mask_ignore: assert property (ex_and && ((io_sync_q ^ w_q[2]) & w_q[1]) != 16'h0000
        |=> !branch_taken && pc_q == $past(pc_q) + 16'(jump_dec_pkg::LEN_INPUT_AND))
        else $error("enabled mismatch did not fall through");
    a_level_match: assert property (ex_and && w_q[1] != 16'h0000
        && (io_sync_q & w_q[1]) == (w_q[2] & w_q[1]) |=> branch_taken)
        else $error("matching levels did not branch");
    a_zero_masks: assert property (ex_and && w_q[1] == 16'h0000 && w_q[2] == 16'h0000
        |=> branch_taken && pc_q == w_q[3]) else $error("zero masks did not branch");
    a_and_target: assert property (ex_and && ((io_sync_q ^ w_q[2]) & w_q[1]) == 16'h0000
        |=> pc_q == $past(w_q[3]) && step_done) else $error("input-AND target not loaded");
    a_bad_op: assert property (ex_reg && op_code != jump_dec_pkg::OP_GREATER_EQUAL
        && op_code != jump_dec_pkg::OP_GREATER_THAN |=> bad_instr && $stable(pc_q))
        else $error("unknown operation not flagged");
    a_ge_branch: assert property (ex_reg && op_code == jump_dec_pkg::OP_GREATER_EQUAL
        && $signed(reg_rd_data) >= $signed({w_q[2], w_q[3]}) |=> branch_taken ##1 !step_done)
        else $error("greater-equal not taken");
    a_gt_range: assert property (ex_reg && op_code == jump_dec_pkg::OP_GREATER_THAN
        && reg_num > STD_REG_LAST |=> !branch_taken && bad_instr)
        else $error("extended register accepted by greater-than");
    a_signed_cmp: assert property (ex_reg && op_code == jump_dec_pkg::OP_GREATER_THAN
        && reg_num <= STD_REG_LAST && reg_rd_data[31] && !w_q[2][15] |=> !branch_taken)
        else $error("comparison not signed");
    a_target_exact: assert property (step_done && branch_taken
        |-> pc_q == ((w_q[0] == jump_dec_pkg::CMD_INPUT_AND) ? w_q[3] : w_q[4])) else $error("target mismatch");
    a_reg_fall: assert property (ex_reg && op_code == jump_dec_pkg::OP_GREATER_EQUAL
        && $signed(reg_rd_data) < $signed({w_q[2], w_q[3]})
        |=> pc_q == $past(pc_q) + 16'(jump_dec_pkg::LEN_REG_CMP) && !bad_instr)
        else $error("false comparison did not fall through");

    c_and_taken: cover property (ex_and ##1 branch_taken);
    c_ge_fall: cover property (ex_reg && op_code == 8'h01 ##1 !branch_taken);
    c_gt_taken: cover property (ex_reg && op_code == 8'h04 ##1 branch_taken);
    c_bad: cover property (step_done && bad_instr);
endmodule

`default_nettype wire

/* File: verif/reg_file_model.sv */
`default_nettype none

module reg_file_model (
    input wire logic ref_clk,
    input wire logic wr_en,
    input wire logic [7:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic [7:0] reg_rd_addr,
    output logic [31:0] reg_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] regs_q [256];

    // Written only by the bench, never by the decoder
    always @(posedge ref_clk) begin
        if (wr_en) begin
            regs_q[wr_addr] <= wr_data;
        end
    end

    // Combinational read, same clock as the decoder
    assign reg_rd_data = regs_q[reg_rd_addr];
endmodule

`default_nettype wire

/* File: verif/tb_conditional_jump_decoder.sv */
`default_nettype none

module tb_conditional_jump_decoder;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [79:0] words;
        logic [15:0] ins;
        logic [7:0] reg_n;
        logic [31:0] reg_v;
        logic taken;
        logic bad;
    } row_t;

    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic load_valid = 1'b0;
    logic [15:0] load_addr = 16'h0000;
    logic [15:0] load_data = 16'h0000;
    logic pc_set = 1'b0;
    logic [15:0] pc_set_value = 16'h0000;
    logic step_req = 1'b0;
    logic [15:0] input_state_word = 16'h0000;
    logic [31:0] reg_rd_data;
    logic [7:0] reg_rd_addr;
    logic [15:0] pc;
    logic busy;
    logic step_done;
    logic branch_taken;
    logic bad_instr;
    logic rf_wr = 1'b0;
    logic [7:0] rf_addr = 8'h00;
    logic [31:0] rf_data = 32'h0000_0000;
    int err_count = 0;
    int compares = 0;
    row_t rows [17];

    always #5 ref_clk = ~ref_clk;

    conditional_jump_decoder #(.DEPTH(256), .STD_REG_LAST(8'h3F)) conditional_jump_decoder_i (
        .ref_clk(ref_clk), .arst_n(arst_n), .load_valid(load_valid), .load_addr(load_addr),
        .load_data(load_data), .pc_set(pc_set), .pc_set_value(pc_set_value), .step_req(step_req),
        .input_state_word(input_state_word), .reg_rd_data(reg_rd_data), .reg_rd_addr(reg_rd_addr),
        .pc(pc), .busy(busy), .step_done(step_done), .branch_taken(branch_taken), .bad_instr(bad_instr)
    );

    reg_file_model reg_file_model_i (
        .ref_clk(ref_clk), .wr_en(rf_wr), .wr_addr(rf_addr), .wr_data(rf_data),
        .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data)
    );

    function automatic row_t and_row(input logic [15:0] en, input logic [15:0] st, input logic [15:0] tgt,
                                     input logic [15:0] ins, input logic tk);
        return '{{jump_dec_pkg::CMD_INPUT_AND, en, st, tgt, 16'h0000}, ins, 8'h00, 32'h0000_0000, tk, 1'b0};
    endfunction

    function automatic row_t reg_row(input logic [7:0] op, input logic [7:0] rn, input logic [31:0] val,
                                     input logic [31:0] rv, input logic [15:0] tgt, input logic tk,
                                     input logic bd);
        return '{{jump_dec_pkg::CMD_REG_CMP, op, rn, val, tgt}, 16'h0000, rn, rv, tk, bd};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic load(input logic [15:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        load_valid = 1'b1;
        load_addr = a;
        load_data = d;
        @(negedge ref_clk);
        load_valid = 1'b0;
    endtask

    task automatic set_pc(input logic [15:0] v);
        @(negedge ref_clk);
        pc_set = 1'b1;
        pc_set_value = v;
        @(negedge ref_clk);
        pc_set = 1'b0;
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (step_done !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 40) begin
            err_count++;
            $display("ERROR at %0t: step never finished", $time);
        end
    endtask

    task automatic do_step();
        @(negedge ref_clk);
        step_req = 1'b1;
        @(negedge ref_clk);
        step_req = 1'b0;
        wait_done();
    endtask

    task automatic run_row(input int i);
        row_t r;
        logic [15:0] base;
        logic is_and;
        logic [15:0] tgt;
        r = rows[i];
        base = 16'(i * 8);
        is_and = (r.words[79:64] === jump_dec_pkg::CMD_INPUT_AND);
        tgt = is_and ? r.words[31:16] : r.words[15:0];
        @(negedge ref_clk);
        rf_wr = 1'b1;
        rf_addr = r.reg_n;
        rf_data = r.reg_v;
        @(negedge ref_clk);
        rf_wr = 1'b0;
        for (int k = 0; k < 5; k++) begin
            load(base + 16'(k), r.words[79 - 16 * k -: 16]);
        end
        input_state_word = r.ins;
        set_pc(base);
        do_step();
        check(32'(pc), 32'(r.taken ? tgt : (r.bad ? base : base + (is_and ? 16'h0004 : 16'h0005))));
        check(32'(branch_taken), 32'(r.taken));
        check(32'(bad_instr), 32'(r.bad));
        check(32'(busy), 32'h0000_0000);
        if (!is_and && !r.bad) begin
            check(32'(reg_rd_addr), 32'(r.reg_n));
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        err_count++;
        print_verdict();
    end

    initial begin
        // ****************************************
        // Table of ordinary cases
        // ****************************************
        rows[0] = and_row(16'hF000, 16'hF000, 16'h0010, 16'hF0A5, 1'b1);
        rows[1] = and_row(16'hF000, 16'hF000, 16'h0010, 16'h70A5, 1'b0);
        rows[2] = and_row(16'h00FF, 16'h0055, 16'h0020, 16'hFF55, 1'b1);
        rows[3] = and_row(16'h00FF, 16'h0055, 16'h0020, 16'hFF54, 1'b0);
        rows[4] = and_row(16'h0000, 16'h0000, 16'h0030, 16'h0000, 1'b1);
        rows[5] = and_row(16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 1'b1);
        rows[6] = reg_row(8'h01, 8'h20, 32'h0000_04B0, 32'h0000_04B0, 16'h000A, 1'b1, 1'b0);
        rows[7] = reg_row(8'h01, 8'h20, 32'h0000_04B0, 32'h0000_04AF, 16'h000A, 1'b0, 1'b0);
        rows[8] = reg_row(8'h04, 8'h20, 32'h0000_04B0, 32'h0000_04B0, 16'h000A, 1'b0, 1'b0);
        rows[9] = reg_row(8'h04, 8'h3F, 32'h0000_04B0, 32'h0000_04B1, 16'hABCD, 1'b1, 1'b0);
        rows[10] = reg_row(8'h01, 8'hC8, 32'hFFFF_FFFB, 32'hFFFF_FFFB, 16'h0042, 1'b1, 1'b0);
        rows[11] = reg_row(8'h04, 8'h01, 32'hFFFF_FFFE, 32'hFFFF_FFFF, 16'h0044, 1'b1, 1'b0);
        rows[12] = reg_row(8'h01, 8'h02, 32'h7FFF_FFFF, 32'h8000_0000, 16'h0046, 1'b0, 1'b0);
        rows[13] = reg_row(8'h04, 8'h40, 32'h0000_0000, 32'h0000_0001, 16'h0048, 1'b0, 1'b1);
        rows[14] = reg_row(8'h02, 8'h20, 32'h0000_0000, 32'h0000_0001, 16'h004A, 1'b0, 1'b1);
        rows[15] = reg_row(8'h01, 8'h20, 32'h0000_0000, 32'h0000_0001, 16'h004C, 1'b0, 1'b1);
        rows[15].words[79:64] = 16'h00A2;
        rows[16] = reg_row(8'h04, 8'h10, 32'h0000_0005, 32'h8000_0005, 16'h004E, 1'b0, 1'b0);
        repeat (2) @(negedge ref_clk);
        arst_n = 1'b1;
        for (int i = 0; i < 17; i++) begin
            run_row(i);
        end
        // ****************************************
        // Requests while busy: program counter load and program load
        // ****************************************
        for (int k = 0; k < 4; k++) begin
            load(16'(200 + k), rows[0].words[79 - 16 * k -: 16]);
        end
        input_state_word = 16'hF000;
        set_pc(16'd200);
        @(negedge ref_clk);
        step_req = 1'b1;
        @(negedge ref_clk);
        step_req = 1'b0;
        check(32'(busy), 32'h0000_0001);
        pc_set = 1'b1;
        pc_set_value = 16'h1234;
        load_valid = 1'b1;
        load_addr = 16'd200;
        load_data = 16'h0000;
        @(negedge ref_clk);
        pc_set = 1'b0;
        load_valid = 1'b0;
        wait_done();
        check(32'(pc), 32'h0000_0010);
        // Program counter load wins over a step in the same cycle
        @(negedge ref_clk);
        pc_set = 1'b1;
        pc_set_value = 16'h00C8;
        step_req = 1'b1;
        @(negedge ref_clk);
        pc_set = 1'b0;
        step_req = 1'b0;
        check(32'(busy), 32'h0000_0000);
        check(32'(pc), 32'h0000_00C8);
        load(16'h01C8, 16'h0000);
        set_pc(16'd200);
        do_step();
        check(32'(pc), 32'h0000_0010);
        check(32'(branch_taken), 32'h0000_0001);
        // ****************************************
        // Reset in the middle of a step
        // ****************************************
        set_pc(16'd200);
        @(negedge ref_clk);
        step_req = 1'b1;
        @(negedge ref_clk);
        step_req = 1'b0;
        repeat (3) @(negedge ref_clk);
        arst_n = 1'b0;
        @(negedge ref_clk);
        check(32'({pc, busy, step_done, branch_taken, bad_instr, reg_rd_addr}), 32'h0000_0000);
        arst_n = 1'b1;
        // Program survives reset; a fresh step must work again
        set_pc(16'h00C8);
        do_step();
        check(32'(pc), 32'h0000_0010);
        check(32'(branch_taken), 32'h0000_0001);
        @(negedge ref_clk);
        print_verdict();
    end
endmodule

`default_nettype wire
